/* File: bench/dps_master.sv */
// single-wire bus master model, mostly overdrive slot timing
`timescale 1ns/1ps
module dps_master (
  input  wire logic clk,
  input  wire logic line_oe,
  output logic      line_in
);
  // long enough to clear the device hold point plus hold-off
  localparam int SLOT = 440;

  logic low;

  initial low = 1'b0;

  // wired-and with pull-up: released line goes high
  assign line_in = ~(low | line_oe);

  task automatic hold_low(input int n);
    low <= 1'b1;
    repeat (n) @(posedge clk);
    low <= 1'b0;
  endtask

  // reset pulse, then presence sampled inside its low phase
  task automatic bus_reset(input int len, output logic pres);
    @(posedge clk);
    hold_low(len);
    repeat (350) @(posedge clk);
    pres = line_in;
    repeat (300) @(posedge clk);
  endtask

  // optional glitch after a one-bit rise, short of the hold-off
  task automatic write_bit(input logic b, input logic glitch);
    int used;
    used = b ? 5 : 320;
    @(posedge clk);
    hold_low(used);
    if (b && glitch) begin
      repeat (30) @(posedge clk);
      hold_low(10);
      used += 40;
    end
    repeat (SLOT - used) @(posedge clk);
  endtask

  // read slot opens like write-one; low time, sample point, slot length
  task automatic read_slot(input int low_n, input int smp, input int len,
                           output logic b);
    @(posedge clk);
    hold_low(low_n);
    repeat (smp - low_n) @(posedge clk);
    b = line_in;
    // single slave only, plain recovery is enough
    repeat (len - smp) @(posedge clk);
  endtask

  // overdrive read slot, short low time
  task automatic read_bit(output logic b);
    read_slot(5, 150, SLOT, b);
  endtask

  task automatic write_byte(input logic [7:0] d, input logic glitch);
    for (int i = 0; i < 8; i++) begin
      write_bit(d[i], glitch);
    end
  endtask

  task automatic read_byte(output logic [7:0] d);
    for (int i = 0; i < 8; i++) begin
      read_bit(d[i]);
    end
  endtask
endmodule

/* File: bench/testbench.sv */
// self-checking bench for the two-channel pin switch
`timescale 1ns/1ps
module testbench;
  logic       clk;
  logic       rst_n;
  logic       overdrive;
  logic [1:0] ext_low;
  logic [1:0] pin_in;
  logic       line_in;
  logic       line_out;
  logic       line_oe;
  logic [1:0] pin_out;
  logic [1:0] pin_oe;
  int         n_errors;
  int         checks;
  int         cycles;

  dps_switch #(
    .RST_STD(4000),
    .RST_OD (400),
    .PDL_STD(300),
    .PDL_OD (100),
    .DEPTH  (4)
  ) uut (
    .clk      (clk),
    .rst_n    (rst_n),
    .line_in  (line_in),
    .line_out (line_out),
    .line_oe  (line_oe),
    .overdrive(overdrive),
    .pin_in   (pin_in),
    .pin_out  (pin_out),
    .pin_oe   (pin_oe)
  );

  dps_master master (
    .clk    (clk),
    .line_oe(line_oe),
    .line_in(line_in)
  );

  // pulled-up pins, an outside switch may pull one low
  assign pin_in = ~(pin_oe | ext_low);

  always #5 clk = ~clk;

  task automatic check(input string what, input logic [7:0] seen,
                       input logic [7:0] exp);
    checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic conclude();
    $display("errors %0d checks %0d", n_errors, checks);
    if (n_errors == 0 && checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  task automatic open_access(input logic [7:0] cmd, input logic glitch);
    logic pres;
    master.bus_reset(450, pres);
    check("presence", {7'h00, pres}, 8'h00);
    master.write_byte(dps_pkg::CMD_SKIP_ROM, 1'b0);
    master.write_byte(cmd, glitch);
  endtask

  // status stream, second pin held low outside, glitchy command;
  // then a short and a long low at standard speed against the fall filter
  task automatic read_stream();
    logic [7:0] d;
    check("pin_oe reset", {6'h00, pin_oe}, 8'h00);
    check("drive values", {5'h00, line_out, pin_out}, 8'h00);
    @(posedge clk);
    ext_low <= 2'h2;
    open_access(dps_pkg::CMD_PIN_READ, 1'b1);
    for (int i = 0; i < 2; i++) begin
      master.read_byte(d);
      check("read status", d, 8'h4B);
    end
    d = 8'h00;
    master.read_bit(d[0]);
    master.read_bit(d[1]);
    @(posedge clk);
    overdrive <= 1'b0;
    master.read_slot(5, 1500, 3000, d[2]);
    master.read_slot(15, 1500, 3000, d[3]);
    check("std filter", d, 8'h07);
    @(posedge clk);
    overdrive <= 1'b1;
  endtask

  // two successive writes, confirm and status each time
  task automatic write_pins();
    logic [7:0] d;
    @(posedge clk);
    ext_low <= 2'h0;
    open_access(dps_pkg::CMD_PIN_WRITE, 1'b0);
    master.write_byte(8'hFC, 1'b0);
    master.write_byte(8'h03, 1'b0);
    master.read_byte(d);
    check("confirm 1", d, 8'hAA);
    master.read_byte(d);
    check("status 1", d, 8'hF0);
    check("pin_oe 1", {6'h00, pin_oe}, 8'h03);
    master.write_byte(8'hFD, 1'b0);
    master.write_byte(8'h02, 1'b0);
    master.read_byte(d);
    check("confirm 2", d, 8'hAA);
    master.read_byte(d);
    check("status 2", d, 8'hC3);
    check("pin_oe 2", {6'h00, pin_oe}, 8'h02);
  endtask

  // inverse mismatch: ones forever, latches untouched
  task automatic bad_inverse();
    logic [7:0] d;
    open_access(dps_pkg::CMD_PIN_WRITE, 1'b0);
    master.write_byte(8'h01, 1'b0);
    master.write_byte(8'h01, 1'b0);
    for (int i = 0; i < 2; i++) begin
      master.read_byte(d);
      check("invalid", d, dps_pkg::BYTE_INVALID);
    end
    check("pin_oe kept", {6'h00, pin_oe}, 8'h02);
  endtask

  // run is about 81000 cycles; ceiling leaves some margin
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 90000) begin
      n_errors++;
      conclude();
    end
  end

  initial begin
    clk = 1'b0;
    rst_n = 1'b0;
    overdrive = 1'b1;
    ext_low = 2'h0;
    n_errors = 0;
    checks = 0;
    cycles = 0;
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    repeat (5) @(posedge clk);
    read_stream();
    write_pins();
    bad_inverse();
    conclude();
  end
endmodule

/* File: common/dps_pkg.sv */
// shared constants, types and helpers of the two-channel pin switch
package dps_pkg;

  localparam int CLK_NS = 10;

  // slot timing, standard and overdrive speed, in ns
  localparam int SAMPLE_STD_NS = 30000;
  localparam int SAMPLE_OD_NS  = 3000;
  localparam int HOLD_STD_NS   = 25000;
  localparam int HOLD_OD_NS    = 2500;
  localparam int RST_STD_NS    = 480000;
  localparam int RST_OD_NS     = 48000;
  localparam int PDH_STD_NS    = 30000;
  localparam int PDH_OD_NS     = 3000;
  localparam int PDL_STD_NS    = 120000;
  localparam int PDL_OD_NS     = 12000;
  localparam int HOLDOFF_NS    = 1000;
  localparam int FILT_NS       = 100;

  function automatic int cyc_up(input int ns);
    int c;
    c = (ns + CLK_NS - 1) / CLK_NS;
    return (c < 1) ? 1 : c;
  endfunction

  function automatic int cyc_dn(input int ns);
    int c;
    c = ns / CLK_NS;
    return (c < 1) ? 1 : c;
  endfunction

  localparam int SAMPLE_STD_CYC = cyc_up(SAMPLE_STD_NS);
  localparam int SAMPLE_OD_CYC  = cyc_up(SAMPLE_OD_NS);
  localparam int HOLD_STD_CYC   = cyc_dn(HOLD_STD_NS);
  localparam int HOLD_OD_CYC    = cyc_dn(HOLD_OD_NS);
  localparam int RST_STD_CYC    = cyc_up(RST_STD_NS);
  localparam int RST_OD_CYC     = cyc_up(RST_OD_NS);
  localparam int PDH_STD_CYC    = cyc_up(PDH_STD_NS);
  localparam int PDH_OD_CYC     = cyc_up(PDH_OD_NS);
  localparam int PDL_STD_CYC    = cyc_up(PDL_STD_NS);
  localparam int PDL_OD_CYC     = cyc_up(PDL_OD_NS);
  localparam int HOLDOFF_CYC    = cyc_up(HOLDOFF_NS);
  localparam int FILT_CYC       = cyc_up(FILT_NS);

  localparam logic [7:0] CMD_SKIP_ROM  = 8'hCC;
  localparam logic [7:0] CMD_PIN_READ  = 8'hF5;
  localparam logic [7:0] CMD_PIN_WRITE = 8'h5A;
  localparam logic [7:0] BYTE_CONFIRM  = 8'hAA;
  localparam logic [7:0] BYTE_INVALID  = 8'hFF;
  localparam logic [1:0] LATCH_RESET   = 2'h3;

  typedef enum logic [3:0] {
    PH_IDLE, PH_PRES_WAIT, PH_PRES_LOW, PH_ROM, PH_FUNC,
    PH_READ, PH_WR_DATA, PH_WR_INV, PH_WR_TX, PH_WR_WAIT, PH_INVALID
  } dps_phase_e;

  typedef struct packed {
    logic fall;
    logic rose;
    logic high;
  } dps_line_s;

  typedef struct packed {
    logic       high;
    logic [7:0] lowrun;
    logic [7:0] hold;
    logic       fall;
    logic       rose;
  } dps_filt_s;

  typedef struct packed {
    dps_phase_e  phase;
    logic [15:0] timer;
    logic        in_slot;
    logic [2:0]  bitcnt;
    logic [7:0]  shreg;
    logic [7:0]  wdata;
    logic        drive;
    logic [1:0]  latch;
    logic        step;
  } dps_state_s;

  // low nibble pin a, latch a, pin b, latch b; high nibble its inverse
  function automatic logic [7:0] status_byte(input logic [1:0] pins,
                                             input logic [1:0] latch);
    logic [3:0] lo;
    lo = {latch[1], pins[1], latch[0], pins[0]};
    return {~lo, lo};
  endfunction

endpackage

/* File: rtl/dps_fifo.sv */
// small valid/ready fifo for outgoing bytes
`timescale 1ns/1ps
module dps_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 4
) (
  input  wire logic             clk,
  input  wire logic             rst_n,
  input  wire logic             flush,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW-1:0]               rd;
    logic [AW-1:0]               wr;
    logic [AW:0]                 cnt;
  } dps_fifo_s;

  dps_fifo_s st;
  dps_fifo_s next_st;
  logic      push;
  logic      pop;

  function automatic logic [AW-1:0] bump(input logic [AW-1:0] p);
    return (p == AW'(DEPTH - 1)) ? '0 : p + AW'(1);
  endfunction

  assign in_ready  = (st.cnt != (AW+1)'(DEPTH));
  assign out_valid = (st.cnt != '0);
  assign out_data  = st.mem[st.rd];
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  always_comb begin
    next_st = st;
    if (push) begin
      next_st.mem[st.wr] = in_data;
      next_st.wr = bump(st.wr);
    end
    if (pop) begin
      next_st.rd = bump(st.rd);
    end
    next_st.cnt = st.cnt + (AW+1)'(push) - (AW+1)'(pop);
    if (flush) begin
      next_st.rd  = '0;
      next_st.wr  = '0;
      next_st.cnt = '0;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  a_fifo_bound: assert property (@(posedge clk) disable iff (!rst_n)
    st.cnt <= (AW+1)'(DEPTH))
    else $error("fifo count above depth");
endmodule

/* File: rtl/dps_line_filter.sv */
// slot-start detector with fall filter and rising-edge hold-off
`timescale 1ns/1ps
module dps_line_filter #(
  parameter int FILT = dps_pkg::FILT_CYC,
  parameter int HOLD = dps_pkg::HOLDOFF_CYC
) (
  input  wire logic            clk,
  input  wire logic            rst_n,
  input  wire logic            line_in,
  input  wire logic            overdrive,
  output dps_pkg::dps_line_s   line
);
  dps_pkg::dps_filt_s st;
  dps_pkg::dps_filt_s next_st;
  logic [7:0]         need;

  // the long filter costs slot margin, so overdrive skips it
  assign need = overdrive ? 8'h01 : 8'(FILT); // [RQ8]

  always_comb begin
    next_st      = st;
    next_st.fall = 1'b0;
    next_st.rose = 1'b0;
    if (!line_in) begin
      next_st.lowrun = (st.lowrun == 8'hFF) ? st.lowrun : st.lowrun + 8'h01;
    end else begin
      next_st.lowrun = 8'h00; // a glitch that ends resets the run [RQ9]
    end
    if (st.hold != 8'h00) begin
      next_st.hold = st.hold - 8'h01;
    end
    if (st.high) begin
      // a low still present once hold-off has run out starts a slot
      if (!line_in && (st.lowrun + 8'h01 >= need) && st.hold == 8'h00) begin
        next_st.high = 1'b0; // [RQ10] [RQ18]
        next_st.fall = 1'b1;
      end
    end else if (line_in) begin
      next_st.high = 1'b1;
      next_st.rose = 1'b1;
      next_st.hold = 8'(HOLD); // [RQ9]
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st <= '{high: 1'b1, default: '0};
    end else begin
      st <= next_st;
    end
  end

  assign line.fall = st.fall;
  assign line.rose = st.rose;
  assign line.high = st.high;

  a_holdoff_quiet: assert property (@(posedge clk) disable iff (!rst_n) // [RQ9]
    $rose(st.high) |-> !st.fall [*2])
    else $error("slot start inside hold-off");
  a_std_filter: assert property (@(posedge clk) disable iff (!rst_n) // [RQ8]
    (next_st.fall && !overdrive) |-> st.lowrun + 8'h01 >= 8'(FILT))
    else $error("fall taken before filter length");
endmodule

/* File: rtl/dps_switch.sv */
// slave end of the single-wire link with two open-drain pins
// How it works
// (RQ1) master opens read slot like write-one
// (RQ2) zero bit: pull low, release at hold
// (RQ3) one bit: never pull the line low
// (RQ4) master samples inside its sampling window
// (RQ5) master waits full slot for recovery
// (RQ6) master keeps read low time short
// (RQ7) many slaves: master lengthens recovery
// (RQ8) fall filter at standard speed only
// (RQ9) ignore glitches ending inside hold-off
// (RQ10) low past hold-off starts new slot
// (RQ11) reset, presence, select, then function command
// (RQ12) read command streams status bytes until reset
// (RQ13) write: byte, inverse, confirm, status
// (RQ14) write exchange repeats until reset
// (RQ15) bad inverse: keep outputs, send FF forever
// (RQ16) single slave may use skip selection
// (RQ17) input sensing needs latch at one
// (RQ18) slot timer starts at line fall
// (RQ19) bytes go least significant bit first
// (RQ20) bit0 first channel, bit1 second channel
`timescale 1ns/1ps
module dps_switch #(
  parameter int RST_STD = dps_pkg::RST_STD_CYC,
  parameter int RST_OD  = dps_pkg::RST_OD_CYC,
  parameter int PDL_STD = dps_pkg::PDL_STD_CYC,
  parameter int PDL_OD  = dps_pkg::PDL_OD_CYC,
  parameter int DEPTH   = 4
) (
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire logic       line_in,
  output logic            line_out,
  output logic            line_oe,
  input  wire logic       overdrive,
  input  wire logic [1:0] pin_in,
  output logic      [1:0] pin_out,
  output logic      [1:0] pin_oe
);
  dps_pkg::dps_state_s st;
  dps_pkg::dps_state_s next_st;
  dps_pkg::dps_line_s  line;

  logic        push_valid;
  logic        push_ready;
  logic [7:0]  push_data;
  logic        tx_valid;
  logic        tx_pop;
  logic [7:0]  tx_data;
  logic        flush;
  logic        tx_mode;
  logic        byte_done;
  logic [7:0]  rx_byte;
  logic [15:0] t_sample;
  logic [15:0] t_hold;
  logic [15:0] t_rst;
  logic [15:0] t_pdh;
  logic [15:0] t_pdl;

  dps_line_filter u_filt (
    .clk       (clk),
    .rst_n     (rst_n),
    .line_in   (line_in),
    .overdrive (overdrive),
    .line      (line)
  );

  // outgoing bytes queue here; a full queue stalls the producer
  dps_fifo #(
    .WIDTH (8),
    .DEPTH (DEPTH)
  ) u_txq (
    .clk       (clk),
    .rst_n     (rst_n),
    .flush     (flush),
    .in_valid  (push_valid),
    .in_ready  (push_ready),
    .in_data   (push_data),
    .out_valid (tx_valid),
    .out_ready (tx_pop),
    .out_data  (tx_data)
  );

  assign t_sample = overdrive ? 16'(dps_pkg::SAMPLE_OD_CYC)
                              : 16'(dps_pkg::SAMPLE_STD_CYC);
  assign t_hold   = overdrive ? 16'(dps_pkg::HOLD_OD_CYC)
                              : 16'(dps_pkg::HOLD_STD_CYC);
  assign t_rst    = overdrive ? 16'(RST_OD) : 16'(RST_STD);
  assign t_pdh    = overdrive ? 16'(dps_pkg::PDH_OD_CYC)
                              : 16'(dps_pkg::PDH_STD_CYC);
  assign t_pdl    = overdrive ? 16'(PDL_OD) : 16'(PDL_STD);

  assign tx_mode = st.phase inside {dps_pkg::PH_READ, dps_pkg::PH_WR_TX,
                                    dps_pkg::PH_WR_WAIT,
                                    dps_pkg::PH_INVALID};
  assign rx_byte = {line_in, st.shreg[7:1]}; // [RQ19]

  always_comb begin
    next_st    = st;
    push_valid = 1'b0;
    push_data  = 8'h00;
    tx_pop     = 1'b0;
    flush      = 1'b0;
    byte_done  = 1'b0;
    if (st.timer != 16'hFFFF) begin
      next_st.timer = st.timer + 16'h0001;
    end

    unique case (st.phase)
      dps_pkg::PH_PRES_WAIT: begin
        if (st.timer == t_pdh) begin
          next_st.drive = 1'b1; // [RQ11]
          next_st.timer = 16'h0000;
          next_st.phase = dps_pkg::PH_PRES_LOW;
        end
      end
      dps_pkg::PH_PRES_LOW: begin
        if (st.timer == t_pdl) begin
          next_st.drive = 1'b0;
          next_st.phase = dps_pkg::PH_ROM;
        end
      end
      default: begin
        // slot timer runs from the filtered fall
        if (line.fall) begin
          next_st.timer   = 16'h0000; // [RQ18]
          next_st.in_slot = 1'b1;
          if (tx_mode && tx_valid) begin
            // only a zero pulls; a one leaves the line to rise [RQ2] [RQ3]
            next_st.drive = ~tx_data[st.bitcnt]; // [RQ19]
          end
        end
        // a slot ends at its own sample or hold point, not at the rise,
        // since a one bit rises long before either
        if (st.in_slot && st.timer == t_sample && !tx_mode) begin
          next_st.in_slot = 1'b0;
          next_st.shreg  = rx_byte;
          next_st.bitcnt = st.bitcnt + 3'h1;
          byte_done      = (st.bitcnt == 3'h7);
        end
        if (st.in_slot && st.timer == t_hold && tx_mode) begin
          next_st.in_slot = 1'b0;
          next_st.drive = 1'b0; // [RQ2]
          if (tx_valid) begin
            next_st.bitcnt = st.bitcnt + 3'h1;
            tx_pop         = (st.bitcnt == 3'h7);
          end
        end
        if (line.rose) begin
          if (st.timer >= t_rst) begin
            // a long low outside the presence phases restarts the whole access [RQ11]
            flush           = 1'b1;
            next_st.in_slot = 1'b0;
            next_st.drive   = 1'b0;
            next_st.bitcnt  = 3'h0;
            next_st.timer   = 16'h0000;
            next_st.phase   = dps_pkg::PH_PRES_WAIT;
          end
        end
      end
    endcase

    if (byte_done && !flush) begin
      unique case (st.phase)
        dps_pkg::PH_ROM: begin
          // only skip selection is decoded here [RQ16]
          next_st.phase = (rx_byte == dps_pkg::CMD_SKIP_ROM)
                          ? dps_pkg::PH_FUNC : dps_pkg::PH_IDLE;
        end
        dps_pkg::PH_FUNC: begin
          if (rx_byte == dps_pkg::CMD_PIN_READ) begin
            next_st.phase = dps_pkg::PH_READ; // [RQ12]
          end else if (rx_byte == dps_pkg::CMD_PIN_WRITE) begin
            next_st.phase = dps_pkg::PH_WR_DATA; // [RQ13]
          end else begin
            next_st.phase = dps_pkg::PH_IDLE;
          end
        end
        dps_pkg::PH_WR_DATA: begin
          next_st.wdata = rx_byte;
          next_st.phase = dps_pkg::PH_WR_INV;
        end
        dps_pkg::PH_WR_INV: begin
          if (rx_byte == ~st.wdata) begin
            next_st.latch = st.wdata[1:0]; // upper bits ignored [RQ20]
            next_st.step  = 1'b0;
            next_st.phase = dps_pkg::PH_WR_TX; // [RQ13]
          end else begin
            next_st.phase = dps_pkg::PH_INVALID; // latch kept [RQ15]
          end
        end
        default: begin
        end
      endcase
    end

    // status is sampled when queued, so it can lag by queue depth
    if (!flush) begin
      unique case (st.phase)
        dps_pkg::PH_READ: begin
          push_valid = 1'b1;
          push_data  = dps_pkg::status_byte(pin_in, st.latch); // [RQ12]
        end
        dps_pkg::PH_INVALID: begin
          push_valid = 1'b1;
          push_data  = dps_pkg::BYTE_INVALID; // [RQ15]
        end
        dps_pkg::PH_WR_TX: begin
          push_valid = 1'b1;
          push_data  = st.step ? dps_pkg::status_byte(pin_in, st.latch)
                               : dps_pkg::BYTE_CONFIRM; // [RQ13]
          if (push_ready) begin
            next_st.step = ~st.step;
            if (st.step) begin
              next_st.phase = dps_pkg::PH_WR_WAIT;
            end
          end
        end
        dps_pkg::PH_WR_WAIT: begin
          if (!tx_valid) begin
            next_st.bitcnt = 3'h0;
            next_st.phase  = dps_pkg::PH_WR_DATA; // [RQ14]
          end
        end
        default: begin
        end
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st <= '{phase: dps_pkg::PH_IDLE, latch: dps_pkg::LATCH_RESET,
              default: '0};
    end else begin
      st <= next_st;
    end
  end

  assign line_out = 1'b0;
  assign line_oe  = st.drive;
  // a latch at one releases the pin so it can be sensed [RQ17]
  assign pin_out  = 2'b00;
  assign pin_oe   = ~st.latch;

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);

  sequence s_good_inverse;
    byte_done && st.phase == dps_pkg::PH_WR_INV && rx_byte == ~st.wdata;
  endsequence

  sequence s_bad_inverse;
    byte_done && st.phase == dps_pkg::PH_WR_INV && rx_byte != ~st.wdata;
  endsequence

  a_one_bit_silent: assert property ( // [RQ3]
    (line.fall && tx_mode && tx_valid && tx_data[st.bitcnt]
     && st.phase != dps_pkg::PH_PRES_WAIT) |=> !line_oe)
    else $error("line pulled for a one bit");
  a_zero_bit_pull: assert property ( // [RQ2]
    (line.fall && tx_mode && tx_valid && !tx_data[st.bitcnt]
     && !line.rose) |=> line_oe)
    else $error("zero bit not driven");
  a_zero_release: assert property ( // [RQ2]
    (line_oe && st.in_slot && tx_mode) |-> st.timer <= t_hold)
    else $error("zero bit held past hold time");
  a_reset_presence: assert property ( // [RQ11]
    (line.rose && st.timer >= t_rst && st.phase != dps_pkg::PH_PRES_WAIT
     && st.phase != dps_pkg::PH_PRES_LOW)
    |=> st.phase == dps_pkg::PH_PRES_WAIT && !tx_valid)
    else $error("long low did not start presence");
  a_read_status: assert property ( // [RQ12]
    (st.phase == dps_pkg::PH_READ && push_valid)
    |-> push_data == dps_pkg::status_byte(pin_in, st.latch))
    else $error("read stream not status");
  a_write_confirm: assert property ( // [RQ13]
    s_good_inverse |=> st.phase == dps_pkg::PH_WR_TX
                       && push_data == dps_pkg::BYTE_CONFIRM)
    else $error("confirm byte not queued first");
  a_latch_update: assert property ( // [RQ20]
    s_good_inverse |=> st.latch == $past(st.wdata[1:0]))
    else $error("latch not loaded from output byte");
  a_invalid_keep: assert property ( // [RQ15]
    s_bad_inverse |=> $stable(st.latch) && st.phase == dps_pkg::PH_INVALID)
    else $error("bad inverse changed outputs");
  a_invalid_ff: assert property ( // [RQ15]
    (st.phase == dps_pkg::PH_INVALID && push_valid)
    |-> push_data == dps_pkg::BYTE_INVALID)
    else $error("invalid path sent non-FF byte");
  a_write_loop: assert property ( // [RQ14]
    (st.phase == dps_pkg::PH_WR_WAIT && !tx_valid && !flush)
    |=> st.phase == dps_pkg::PH_WR_DATA && st.bitcnt == 3'h0)
    else $error("write exchange did not loop");
endmodule
